//--- dpm_pkg.sv
package dpm_pkg;

  // ===========================================================================
  // array geometry
  localparam int          UNITS      = 4096;
  localparam int          UNIT_W     = 9;
  localparam int          ADDR_W     = 16;
  localparam int          DATA_W     = 72;
  localparam int          PTR_W      = 13;
  localparam logic [12:0] FIFO_UNITS = 13'h1000;
  localparam int          ECC_POS    = 71;

  // ===========================================================================
  // width codes: 1, 2, 4, 9, 18, 36, 72
  localparam logic [2:0] WID_NARROW = 3'h3;
  localparam logic [2:0] WID_18     = 3'h4;
  localparam logic [2:0] WID_36     = 3'h5;
  localparam logic [2:0] WID_72     = 3'h6;

  typedef enum logic [1:0] {
    WM_READ_FIRST  = 2'b00,
    WM_WRITE_FIRST = 2'b01,
    WM_NO_CHANGE   = 2'b10
  } dpm_wrmode_t;

  // ===========================================================================
  // register offsets
  localparam logic [11:0] REG_CTRL     = 12'h000;
  localparam logic [11:0] REG_AFULL    = 12'h004;
  localparam logic [11:0] REG_AEMPTY   = 12'h008;
  localparam logic [11:0] REG_STATUS   = 12'h00C;
  localparam logic [11:0] REG_LASTADDR = 12'h010;
  localparam logic [11:0] REG_ECC_DLO  = 12'h014;
  localparam logic [11:0] REG_ECC_DHI  = 12'h018;
  localparam logic [11:0] REG_ECC_CHK  = 12'h01C;
  localparam logic [11:0] REG_ECC_CLO  = 12'h020;
  localparam logic [11:0] REG_ECC_CHI  = 12'h024;
  localparam logic [11:0] REG_ECC_RES  = 12'h028;

  // ===========================================================================
  // control fields
  localparam int CTRL_WA      = 0;
  localparam int CTRL_WB      = 3;
  localparam int CTRL_MA      = 6;
  localparam int CTRL_MB      = 8;
  localparam int CTRL_OREGA   = 10;
  localparam int CTRL_OREGB   = 11;
  localparam int CTRL_SPLIT   = 12;
  localparam int CTRL_SRW     = 13;
  localparam int CTRL_ECC     = 14;
  localparam int CTRL_FIFO    = 15;
  localparam int CTRL_FWFT    = 16;
  localparam int CTRL_CASC    = 17;
  localparam int CTRL_CUPPER  = 18;
  localparam int CTRL_BITS    = 19;

  localparam logic [18:0] CTRL_RESET   = 19'h00000;
  localparam logic [12:0] AFULL_RESET  = 13'h0FFF;
  localparam logic [12:0] AEMPTY_RESET = 13'h0001;

endpackage

//--- dpm_secded.sv
module dpm_secded
  import dpm_pkg::*;
(
  input  wire logic [63:0] dataIn,
  input  wire logic [7:0]  checkIn,
  output logic      [7:0]  checkOut,
  output logic      [63:0] dataOut,
  output logic             singleErr,
  output logic             doubleErr
);

  logic [6:0] calc;
  logic [6:0] syn;
  logic       overall;

  // ===========================================================================
  // hamming over positions 1..71, data at non power of two slots
  always_comb begin
    int d;
    d = 0;
    calc = '0;
    for (int pos = 1; pos <= ECC_POS; pos++) begin
      if ((pos & (pos - 1)) != 0) begin
        if (dataIn[d]) begin
          calc = calc ^ 7'(pos);
        end
        d = d + 1;
      end
    end
    checkOut = {^dataIn ^ ^calc, calc};
    syn = calc ^ checkIn[6:0];
    overall = ^dataIn ^ ^checkIn;
    singleErr = overall;
    doubleErr = !overall && (syn != 7'h00);
    d = 0;
    dataOut = dataIn;
    for (int pos = 1; pos <= ECC_POS; pos++) begin
      if ((pos & (pos - 1)) != 0) begin
        dataOut[d] = dataIn[d] ^ (overall && (syn == 7'(pos)));
        d = d + 1;
      end
    end
  end

endmodule

//--- dpm_block_ram.sv
module dpm_block_ram
  import dpm_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        enA,
  input  wire logic        weA,
  input  wire logic [15:0] addrA,
  input  wire logic [71:0] dinA,
  input  wire logic        cascInA,
  output logic      [71:0] doutA,
  input  wire logic        enB,
  input  wire logic        weB,
  input  wire logic [15:0] addrB,
  input  wire logic [71:0] dinB,
  input  wire logic        cascInB,
  output logic      [71:0] doutB,
  output logic             fifoFull,
  output logic             fifoEmpty,
  output logic             fifoAlmostFull,
  output logic             fifoAlmostEmpty,
  output logic             eccSingleErr,
  output logic             eccDoubleErr
);

  logic [8:0]  mem [0:UNITS-1];
  logic [18:0] ctrl;
  logic [12:0] afullThr;
  logic [12:0] aemptyThr;
  logic [31:0] extLo;
  logic [31:0] extHi;
  logic [7:0]  extChk;

  logic [15:0] pAddr    [2];
  logic [71:0] pDin     [2];
  logic        pEn      [2];
  logic        pWeIn    [2];
  logic        pCasc    [2];
  logic [2:0]  pCfgW    [2];
  logic [1:0]  pMode    [2];
  logic        pOreg    [2];
  logic [15:0] addrHeld [2];
  logic [71:0] pPipe    [2];
  logic [71:0] pDout    [2];
  logic [2:0]  pW       [2];
  logic [11:0] pIdx     [2];
  logic [2:0]  pPos     [2];
  logic        pWr      [2];
  logic        pRd      [2];
  logic [71:0] pRdData  [2];
  logic [71:0] pWrData  [2];
  logic [71:0] pNew     [2];

  logic        split;
  logic        srw;
  logic        fifoOn;
  logic        fwft;
  logic        cascOn;
  logic        eccOn;
  logic [2:0]  fifoW;
  logic [12:0] fifoDepth;
  logic [11:0] wrPtr;
  logic [11:0] rdPtr;
  logic [12:0] fcount;
  logic        headValid;
  logic        push;
  logic        pop;
  logic [12:0] next_fcount;
  logic        next_headValid;
  logic [7:0]  wrCheck;
  logic [63:0] rdCorr;
  logic        rdSingle;
  logic        rdDouble;
  logic [63:0] extCorr;
  logic [7:0]  extCalc;
  logic        extSingle;
  logic        extDouble;
  logic [71:0] rdRaw;
  logic [31:0] regRead;
  logic        regHit;

  // ===========================================================================
  // helpers
  function automatic logic [2:0] effWidth(logic [2:0] w, logic sp, logic sd, logic fixedSide);
    logic [2:0] cap;
    cap = sp ? (sd ? WID_36 : WID_18) : (sd ? WID_72 : WID_36);
    if (sd && fixedSide) begin
      return cap;
    end
    return (w > cap) ? cap : w;
  endfunction

  function automatic logic [11:0] unitIdx(logic [15:0] a, logic [2:0] w);
    case (w)
      3'h0:    return a[14:3];
      3'h1:    return a[13:2];
      3'h2:    return a[12:1];
      3'h3:    return a[11:0];
      3'h4:    return {a[10:0], 1'b0};
      3'h5:    return {a[9:0], 2'b00};
      default: return {a[8:0], 3'b000};
    endcase
  endfunction

  function automatic logic [2:0] bitPos(logic [15:0] a, logic [2:0] w);
    case (w)
      3'h0:    return a[2:0];
      3'h1:    return {a[1:0], 1'b0};
      3'h2:    return {a[0], 2'b00};
      default: return 3'h0;
    endcase
  endfunction

  function automatic logic [3:0] span(logic [2:0] w);
    return (w < WID_NARROW) ? (4'h1 << w) : (4'h1 << (w - WID_NARROW));
  endfunction

  function automatic logic [71:0] rdWord(logic [11:0] idx, logic [2:0] w, logic [2:0] pos);
    logic [71:0] r;
    r = '0;
    for (int i = 0; i < 8; i++) begin
      if (w < WID_NARROW) begin
        if (i < int'(span(w))) begin
          r[i] = mem[idx][int'(pos) + i];
        end
      end else if (i < int'(span(w))) begin
        r[9*i +: 9] = mem[12'(int'(idx) + i)];
      end
    end
    return r;
  endfunction

  function automatic logic [11:0] nextPtr(logic [11:0] p, logic [12:0] depth);
    return (13'(p) == 13'(depth - 13'h0001)) ? 12'h000 : 12'(p + 12'h001);
  endfunction

  // ===========================================================================
  // port bundling
  assign pAddr[0] = addrA;
  assign pAddr[1] = addrB;
  assign pDin[0]  = dinA;
  assign pDin[1]  = dinB;
  assign pEn[0]   = enA;
  assign pEn[1]   = enB;
  assign pWeIn[0] = weA;
  assign pWeIn[1] = weB;
  assign pCasc[0] = cascInA;
  assign pCasc[1] = cascInB;
  assign pCfgW[0] = ctrl[CTRL_WA +: 3];
  assign pCfgW[1] = ctrl[CTRL_WB +: 3];
  assign pMode[0] = ctrl[CTRL_MA +: 2];
  assign pMode[1] = ctrl[CTRL_MB +: 2];
  assign pOreg[0] = ctrl[CTRL_OREGA];
  assign pOreg[1] = ctrl[CTRL_OREGB];
  assign doutA    = pDout[0];
  assign doutB    = pDout[1];

  assign split  = ctrl[CTRL_SPLIT];
  assign srw    = ctrl[CTRL_SRW];
  assign fifoOn = ctrl[CTRL_FIFO];
  assign fwft   = ctrl[CTRL_FWFT];
  assign cascOn = ctrl[CTRL_CASC];
  assign eccOn  = ctrl[CTRL_ECC] && srw && !fifoOn && (pW[0] == WID_72) && (pW[1] == WID_72);

  // ===========================================================================
  // fifo depth and events
  assign fifoW     = (effWidth(pCfgW[0], split, srw, 1'b0) < WID_NARROW) ?
                     WID_NARROW : effWidth(pCfgW[0], split, srw, 1'b0);
  assign fifoDepth = 13'(FIFO_UNITS >> (fifoW - WID_NARROW));
  assign push      = fifoOn && enA && weA && (fcount != fifoDepth);
  assign pop       = fifoOn && (fcount != 13'h0000) &&
                     (fwft ? (!headValid || enB) : enB);
  assign next_fcount    = 13'(fcount + 13'(push) - 13'(pop));
  assign next_headValid = fwft && (pop || (headValid && !enB));

  // ===========================================================================
  // per-port decode
  always_comb begin
    for (int p = 0; p < 2; p++) begin
      pW[p]   = fifoOn ? fifoW : effWidth(pCfgW[p], split, srw, p == 0);
      pIdx[p] = fifoOn ? unitIdx(16'(p == 0 ? wrPtr : rdPtr), fifoW) : unitIdx(pAddr[p], pW[p]);
      if (split && !fifoOn) begin
        pIdx[p][11] = (p == 1);
      end
      pPos[p] = fifoOn ? 3'h0 : bitPos(pAddr[p], pW[p]);
      pRdData[p] = rdWord(pIdx[p], pW[p], pPos[p]);
      pWrData[p] = pDin[p];
      pWr[p] = pEn[p] && pWeIn[p] && (!srw || p == 0) &&
               (!cascOn || pAddr[p][15] == ctrl[CTRL_CUPPER]);
      pRd[p] = pEn[p] && (!srw || p == 1);
      pNew[p] = pOreg[p] ? pPipe[p] : pDout[p];
    end
    if (fifoOn) begin
      pWr[0] = push;
      pWr[1] = 1'b0;
      pRd[0] = 1'b0;
      pRd[1] = pop;
    end
    if (eccOn) begin
      pWrData[0] = {wrCheck, pDin[0][63:0]};
      pRdData[1] = {pRdData[1][71:64], rdCorr};
    end
    for (int p = 0; p < 2; p++) begin
      if (pRd[p]) begin
        if (pWr[p] && pMode[p] == WM_WRITE_FIRST) begin
          pNew[p] = pWrData[p];
        end else if (!(pWr[p] && pMode[p] == WM_NO_CHANGE)) begin
          pNew[p] = pRdData[p];
          if (cascOn && ctrl[CTRL_CUPPER] && !pAddr[p][15]) begin
            pNew[p] = {71'h0, pCasc[p]};
          end
        end
      end
    end
  end

  // ===========================================================================
  // error code units
  always_comb begin
    rdRaw = rdWord(pIdx[1], pW[1], pPos[1]);
  end

  dpm_secded uEccWr (
    .dataIn    (pDin[0][63:0]),
    .checkIn   (8'h00),
    .checkOut  (wrCheck),
    .dataOut   (),
    .singleErr (),
    .doubleErr ()
  );

  dpm_secded uEccRd (
    .dataIn    (rdRaw[63:0]),
    .checkIn   (rdRaw[71:64]),
    .checkOut  (),
    .dataOut   (rdCorr),
    .singleErr (rdSingle),
    .doubleErr (rdDouble)
  );

  dpm_secded uEccExt (
    .dataIn    ({extHi, extLo}),
    .checkIn   (extChk),
    .checkOut  (extCalc),
    .dataOut   (extCorr),
    .singleErr (extSingle),
    .doubleErr (extDouble)
  );

  // ===========================================================================
  // shared array, port A and, unless CTRL_SRW or CTRL_FIFO is set, port B write on the clock edge only
  always_ff @(posedge ref_clk) begin
    for (int p = 0; p < 2; p++) begin
      if (pWr[p]) begin
        for (int i = 0; i < 8; i++) begin
          if (pW[p] < WID_NARROW) begin
            if (i < int'(span(pW[p])) && int'(pPos[p]) + i < 8) begin
              mem[pIdx[p]][int'(pPos[p]) + i] <= pWrData[p][i];
            end
          end else if (i < int'(span(pW[p]))) begin
            mem[12'(int'(pIdx[p]) + i)] <= pWrData[p][9*i +: 9];
          end
        end
      end
    end
  end

  // ===========================================================================
  // port output path
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int p = 0; p < 2; p++) begin
        pPipe[p]    <= '0;
        pDout[p]    <= '0;
        addrHeld[p] <= '0;
      end
    end else begin
      for (int p = 0; p < 2; p++) begin
        if (pEn[p]) begin
          addrHeld[p] <= pAddr[p];
        end
        pPipe[p] <= pNew[p];
        pDout[p] <= pOreg[p] ? pPipe[p] : pNew[p];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      eccSingleErr <= 1'b0;
      eccDoubleErr <= 1'b0;
    end else if (eccOn && pRd[1]) begin
      eccSingleErr <= rdSingle;
      eccDoubleErr <= rdDouble;
    end
  end

  // ===========================================================================
  // fifo controller
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      wrPtr           <= '0;
      rdPtr           <= '0;
      fcount          <= '0;
      headValid       <= 1'b0;
      fifoFull        <= 1'b0;
      fifoEmpty       <= 1'b1;
      fifoAlmostFull  <= 1'b0;
      fifoAlmostEmpty <= 1'b1;
    end else if (!fifoOn) begin
      wrPtr           <= '0;
      rdPtr           <= '0;
      fcount          <= '0;
      headValid       <= 1'b0;
      fifoFull        <= 1'b0;
      fifoEmpty       <= 1'b1;
      fifoAlmostFull  <= 1'b0;
      fifoAlmostEmpty <= 1'b1;
    end else begin
      if (push) begin
        wrPtr <= nextPtr(wrPtr, fifoDepth);
      end
      if (pop) begin
        rdPtr <= nextPtr(rdPtr, fifoDepth);
      end
      fcount          <= next_fcount;
      headValid       <= next_headValid;
      fifoFull        <= next_fcount == fifoDepth;
      fifoEmpty       <= fwft ? !next_headValid : (next_fcount == 13'h0000);
      fifoAlmostFull  <= next_fcount >= afullThr;
      fifoAlmostEmpty <= next_fcount <= aemptyThr;
    end
  end

  // ===========================================================================
  // apb register file
  always_comb begin
    regRead = '0;
    regHit  = 1'b1;
    if (paddr == REG_CTRL) begin
      regRead = 32'(ctrl);
    end else if (paddr == REG_AFULL) begin
      regRead = 32'(afullThr);
    end else if (paddr == REG_AEMPTY) begin
      regRead = 32'(aemptyThr);
    end else if (paddr == REG_STATUS) begin
      regRead = {13'h0, fcount, eccDoubleErr, eccSingleErr, fifoAlmostEmpty, fifoAlmostFull, fifoEmpty, fifoFull};
    end else if (paddr == REG_LASTADDR) begin
      regRead = {addrHeld[1], addrHeld[0]};
    end else if (paddr == REG_ECC_DLO) begin
      regRead = extLo;
    end else if (paddr == REG_ECC_DHI) begin
      regRead = extHi;
    end else if (paddr == REG_ECC_CHK) begin
      regRead = 32'(extChk);
    end else if (paddr == REG_ECC_CLO) begin
      regRead = extCorr[31:0];
    end else if (paddr == REG_ECC_CHI) begin
      regRead = extCorr[63:32];
    end else if (paddr == REG_ECC_RES) begin
      regRead = {22'h0, extDouble, extSingle, extCalc};
    end else begin
      regHit = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pready  <= 1'b0;
      prdata  <= '0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !regHit;
      if (psel && !penable) begin
        prdata <= regRead;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl      <= CTRL_RESET;
      afullThr  <= AFULL_RESET;
      aemptyThr <= AEMPTY_RESET;
      extLo     <= '0;
      extHi     <= '0;
      extChk    <= '0;
    end else if (psel && penable && pready && pwrite) begin
      if (paddr == REG_CTRL) begin
        ctrl <= pwdata[CTRL_BITS-1:0];
      end else if (paddr == REG_AFULL) begin
        afullThr <= pwdata[12:0];
      end else if (paddr == REG_AEMPTY) begin
        aemptyThr <= pwdata[12:0];
      end else if (paddr == REG_ECC_DLO) begin
        extLo <= pwdata;
      end else if (paddr == REG_ECC_DHI) begin
        extHi <= pwdata;
      end else if (paddr == REG_ECC_CHK) begin
        extChk <= pwdata[7:0];
      end
    end
  end

endmodule

//--- dpm_block_ram_sva.sv
module dpm_block_ram_sva (
  input wire logic        ref_clk,
  input wire logic        rst_b,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        enA,
  input wire logic        weA,
  input wire logic [71:0] doutA,
  input wire logic        enB,
  input wire logic        fifoFull,
  input wire logic        fifoEmpty,
  input wire logic        eccSingleErr,
  input wire logic        eccDoubleErr
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // ==========================================================================
  // register bus
  property p_ready_after_setup; psel && !penable |=> pready; endproperty
  property p_ready_pulse; pready |=> !pready; endproperty
  property p_ready_in_access; pready |-> psel && penable; endproperty
  property p_err_answer; pslverr |-> pready && prdata == 32'h0; endproperty
  a_ready_after_setup: assert property (p_ready_after_setup) else $error("no answer after setup");
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than one cycle");
  a_ready_in_access: assert property (p_ready_in_access) else $error("pready outside access");
  a_err_answer: assert property (p_err_answer) else $error("error without answer or with data");
  // ==========================================================================
  // ports and fifo
  property p_hold_a; !enA ##1 !enA |=> $stable(doutA); endproperty
  property p_full_by_push; $rose(fifoFull) |-> $past(enA && weA); endproperty
  property p_empty_by_push; $fell(fifoEmpty) |-> $past(enA && weA) || $past(enA && weA, 2); endproperty
  property p_full_by_pop;
    $fell(fifoFull) |-> $past(enB) || $past(enB, 2) || $past(psel && penable && pwrite, 2);
  endproperty
  property p_ecc_excl; !(eccSingleErr && eccDoubleErr); endproperty
  a_hold_a: assert property (p_hold_a) else $error("port A output moved without access");
  a_full_by_push: assert property (p_full_by_push) else $error("full rose without push");
  a_empty_by_push: assert property (p_empty_by_push) else $error("empty fell without push");
  a_full_by_pop: assert property (p_full_by_pop) else $error("full fell without pop");
  a_ecc_excl: assert property (p_ecc_excl) else $error("single and double error together");
  c_full: cover property ($rose(fifoFull));
  c_err: cover property (pslverr);
  c_head: cover property ($fell(fifoEmpty));
endmodule

bind dpm_block_ram dpm_block_ram_sva i_dpm_block_ram_sva (
  .ref_clk, .rst_b, .psel, .penable, .pwrite, .prdata, .pready, .pslverr, .enA, .weA, .doutA, .enB,
  .fifoFull, .fifoEmpty, .eccSingleErr, .eccDoubleErr
);

//--- dpm_port_user.sv
module dpm_port_user (
  input  wire logic        ref_clk,
  output logic             enA,
  output logic             weA,
  output logic      [15:0] addrA,
  output logic      [71:0] dinA,
  output logic             cascInA,
  output logic             enB,
  output logic             weB,
  output logic      [15:0] addrB,
  output logic      [71:0] dinB,
  output logic             cascInB
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    {enA, weA, addrA, dinA, cascInA} = '0;
    {enB, weB, addrB, dinB, cascInB} = '0;
  end
  // ==========================================================================
  // one cycle of traffic, launched after the edge
  task automatic op(input logic ea, input logic wa, input logic [15:0] aa, input logic [71:0] da,
                    input logic eb, input logic [15:0] ab);
    @(posedge ref_clk);
    enA     <= ea;
    weA     <= wa;
    addrA   <= aa;
    dinA    <= da;
    enB     <= eb;
    addrB   <= ab;
    dinB    <= 72'({$urandom, $urandom, $urandom});
    cascInA <= ~cascInA;
    cascInB <= ~cascInB;
  endtask
endmodule

//--- test_dpm_block_ram.sv
module test_dpm_block_ram
  import dpm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        ref_clk, rst_b, psel, penable, pwrite, pready, pslverr, lastErr;
  logic        enA, weA, cascInA, enB, weB, cascInB;
  logic        fifoFull, fifoEmpty, fifoAlmostFull, fifoAlmostEmpty, eccSingleErr, eccDoubleErr;
  logic [11:0] paddr;
  logic [15:0] addrA, addrB, wa[16];
  logic [31:0] pwdata, prdata, r, a;
  logic [71:0] dinA, dinB, doutA, doutB, d, last, v[3], wv[16];
  logic [71:0] q[$];
  int          miscompares, checks, cycles, k;

  dpm_block_ram i_dpm_block_ram (.ref_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .enA, .weA, .addrA, .dinA, .cascInA, .doutA, .enB, .weB, .addrB, .dinB, .cascInB, .doutB,
    .fifoFull, .fifoEmpty, .fifoAlmostFull, .fifoAlmostEmpty, .eccSingleErr, .eccDoubleErr);
  dpm_port_user i_dpm_port_user (.ref_clk, .enA, .weA, .addrA, .dinA, .cascInA, .enB, .weB, .addrB, .dinB,
    .cascInB);

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      miscompares++;
      finish_test();
    end
  end
  // ==========================================================================
  // checking and bus tasks
  task automatic finish_test();
    if (miscompares == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic cmpData(input logic [71:0] got, input logic [71:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmpReg(input logic [31:0] got, input logic [31:0] exp);
    cmpData(72'(got), 72'(exp));
  endtask
  task automatic cmpFlag(input logic [3:0] exp);
    cmpData(72'({fifoFull, fifoEmpty, fifoAlmostFull, fifoAlmostEmpty}), 72'(exp));
  endtask
  function automatic logic [3:0] expFlags(int c);
    return {c == 1024, c == 0, c >= 1000, c <= 3};
  endfunction
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
    int n;
    @(posedge ref_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= ad;
    pwdata  <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    r = prdata;
    lastErr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic op(input logic ea, input logic wa, input logic [15:0] aa, input logic [71:0] da,
                    input logic eb, input logic [15:0] ab);
    i_dpm_port_user.op(ea, wa, aa, da, eb, ab);
  endtask
  task automatic tick();
    op(0, 0, 0, 0, 0, 0);
    #1;
  endtask
  // ==========================================================================
  // main sequence
  initial begin
    rst_b   = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0;
    void'($urandom(44));
    repeat (5) @(posedge ref_clk);
    rst_b <= 1'b1;
    apb(0, REG_CTRL, 0);
    cmpReg(r, 32'(CTRL_RESET));
    apb(0, REG_AFULL, 0);
    cmpReg(r, 32'(AFULL_RESET));
    apb(0, REG_AEMPTY, 0);
    cmpReg(r, 32'(AEMPTY_RESET));
    apb(1, REG_STATUS, 32'hFFFFFFFF);
    apb(0, REG_STATUS, 0);
    cmpReg(r, 32'h0000000A);
    apb(0, 12'h0FC, 0);
    cmpReg({r[30:0], lastErr}, 32'h1);
    // wide writes on A, narrow reads on B
    apb(1, REG_CTRL, 32'(WID_36) | (32'(WID_NARROW) << CTRL_WB));
    for (int i = 0; i < 16; i++) begin
      wa[i] = (i == 15) ? 16'h03FF : 16'(i * 64 + $urandom % 64);
      wv[i] = 72'(36'({$urandom, $urandom}));
      op(1, 1, wa[i], wv[i], 0, 0);
    end
    for (int i = 0; i < 16; i++) begin
      k = $urandom % 4;
      op(0, 0, 0, 0, 1, 16'(wa[i] * 4 + k));
      tick();
      cmpData(doutB, 72'(wv[i][9 * k +: 9]));
    end
    for (int m = 0; m < 3; m++) begin
      apb(1, REG_CTRL, 32'(WID_36) | (32'(WID_36) << CTRL_WB) | (32'(m) << CTRL_MA));
      foreach (v[j]) v[j] = 72'(36'({$urandom, $urandom}));
      op(1, 1, 16'h01F4, v[0], 0, 0);
      op(1, 1, 16'(10 + m), v[1], 0, 0);
      op(1, 0, 16'h01F4, 0, 0, 0);
      op(1, 1, 16'(10 + m), v[2], 0, 0);
      tick();
      cmpData(doutA, m == 0 ? v[1] : m == 1 ? v[2] : v[0]);
    end
    apb(1, REG_CTRL, 32'(WID_36) | (32'(WID_36) << CTRL_WB) | (32'h1 << CTRL_OREGB));
    op(0, 0, 0, 0, 1, 16'h01F4);
    op(0, 0, 0, 0, 1, 16'h000C);
    tick();
    cmpData(doutB, v[0]);
    tick();
    cmpData(doutB, v[2]);
    apb(0, REG_LASTADDR, 0);
    cmpReg(r, 32'h000C000C);
    // fill until refused, then drain until refused
    apb(1, REG_AFULL, 32'h000003E8);
    apb(1, REG_AEMPTY, 32'h3);
    apb(1, REG_CTRL, 32'(WID_36) | (32'(WID_36) << CTRL_WB) | (32'h1 << CTRL_FIFO));
    for (int i = 0; i <= 1024; i++) begin
      d = 72'(36'({$urandom, $urandom}));
      op(1, 1, 0, d, 0, 0);
      tick();
      if (i < 1024) q.push_back(d);
      cmpFlag(expFlags(q.size()));
    end
    for (int i = 0; i <= 1024; i++) begin
      op(0, 0, 0, 0, 1, 0);
      tick();
      if (q.size() > 0) last = q.pop_front();
      cmpData(doutB, last);
      cmpFlag(expFlags(q.size()));
    end
    // head word shown before any read
    apb(1, REG_CTRL, 32'(WID_36) | (32'(WID_36) << CTRL_WB) | (32'h3 << CTRL_FIFO));
    foreach (v[j]) v[j] = 72'(36'({$urandom, $urandom}));
    op(1, 1, 0, v[0], 0, 0);
    op(1, 1, 0, v[1], 0, 0);
    repeat (3) tick();
    cmpData(doutB, v[0]);
    cmpFlag(4'h1);
    for (int i = 0; i < 2; i++) begin
      op(0, 0, 0, 0, 1, 0);
      repeat (3) tick();
      cmpData(doutB, v[1]);
      cmpFlag(i == 0 ? 4'h1 : 4'h5);
    end
    // stored check bits repair one flipped bit and flag two
    apb(1, REG_CTRL, (32'(WID_72) << CTRL_WB) | (32'h1 << CTRL_SRW) | (32'h1 << CTRL_ECC));
    d = 72'({$urandom, $urandom});
    op(1, 1, 16'h0040, d, 0, 0);
    for (int e = 0; e < 3; e++) begin
      op(0, 0, 0, 0, 1, 16'h0040);
      tick();
      if (e < 2) cmpData(72'(doutB[63:0]), d);
      cmpData(72'({eccDoubleErr, eccSingleErr}), 72'(e));
      if (e == 0) last = doutB;
      k = $urandom % 63;
      apb(1, REG_CTRL, (32'(WID_72) << CTRL_WB) | (32'h1 << CTRL_SRW));
      op(1, 1, 16'h0040, {last[71:64], d[63:0] ^ (64'(e == 0 ? 1 : 3) << k)}, 0, 0);
      tick();
      apb(1, REG_CTRL, (32'(WID_72) << CTRL_WB) | (32'h1 << CTRL_SRW) | (32'h1 << CTRL_ECC));
    end
    // error code logic from registers alone
    a = $urandom;
    apb(1, REG_ECC_DLO, a);
    apb(1, REG_ECC_DHI, $urandom);
    apb(0, REG_ECC_RES, 0);
    apb(1, REG_ECC_CHK, {24'h0, r[7:0]});
    apb(0, REG_ECC_RES, 0);
    cmpReg(32'(r[9:8]), 32'h0);
    k = $urandom % 31;
    apb(1, REG_ECC_DLO, a ^ (32'h1 << k));
    apb(0, REG_ECC_CLO, 0);
    cmpReg(r, a);
    apb(0, REG_ECC_RES, 0);
    cmpReg(32'(r[9:8]), 32'h1);
    apb(1, REG_ECC_DLO, a ^ (32'h3 << k));
    apb(0, REG_ECC_RES, 0);
    cmpReg(32'(r[9:8]), 32'h2);
    finish_test();
  end
endmodule
